// *** rtl/dsu_pkg.sv ***
// Constants, field layouts and carrier types of the service unit register front end
package dsu_pkg;

  // --------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------------
  localparam logic [5:0] DSU_IDX_CTRL    = 6'h00;
  localparam logic [5:0] DSU_IDX_EVSTAT  = 6'h01;
  localparam logic [5:0] DSU_IDX_PRSTAT  = 6'h02;
  localparam logic [5:0] DSU_IDX_ADDR    = 6'h04;
  localparam logic [5:0] DSU_IDX_LENGTH  = 6'h08;
  localparam logic [5:0] DSU_IDX_VALUE   = 6'h0C;
  localparam logic [5:0] DSU_IDX_CHAN0   = 6'h10;
  localparam logic [5:0] DSU_IDX_CHAN1   = 6'h14;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int DSU_CTRL_CE_BIT      = 4;
  localparam int DSU_CTRL_SELFTEST_BIT = 3;
  localparam int DSU_CTRL_CRC_BIT     = 2;
  localparam int DSU_CTRL_SOFT_RESET_TRIGGER_BIT   = 0;

  localparam int DSU_EV_PROTECTION_ERROR_FLAG_BIT      = 4;
  localparam int DSU_EV_FAIL_BIT      = 3;
  localparam int DSU_EV_BUS_ERROR_FLAG_BIT      = 2;
  localparam int DSU_EV_RSTEXT_BIT    = 1;
  localparam int DSU_EV_DONE_BIT      = 0;

  localparam int DSU_PR_HPE_BIT       = 4;
  localparam int DSU_PR_DIRTY_LSB     = 2;
  localparam int DSU_PR_PROBE_BIT     = 1;
  localparam int DSU_PR_LOCKED_BIT    = 0;

  localparam int DSU_WORD_LSB         = 2;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [4:0]  DSU_EVSTAT_RST  = 5'h00;
  localparam logic        DSU_HPE_RST     = 1'b1;
  localparam logic [31:0] DSU_ADDR_RST    = 32'h0000_0000;
  localparam logic [29:0] DSU_LENGTH_RST  = 30'h0000_0000;
  localparam logic [31:0] DSU_VALUE_RST   = 32'h0000_0000;
  localparam logic [31:0] DSU_CHAN_RST    = 32'h0000_0000;

  // --------------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic chip_erase;
    logic selftest;
    logic crc;
    logic unit_reset;
  } dsu_cmd_t;

  typedef struct packed {
    logic op_done;
    logic op_fail;
    logic bus_err;
    logic cold_plug;
    logic probe_detect;
    logic swclk_func_changed;
    logic result_valid;
  } dsu_evt_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    dsu_cmd_t    cmd;
    logic [4:0]  evstat;
    logic        hot_plug_enable_flag;
    logic [1:0]  dirty;
    logic        probe;
    logic        locked;
    logic        strap_taken;
    logic [31:0] addr;
    logic [29:0] length;
    logic [31:0] value;
    logic [31:0] chan0;
    logic [31:0] chan1;
  } dsu_state_t;

  localparam dsu_state_t DSU_STATE_RST = '{
    ack:         1'b0,
    rdata:       32'h0000_0000,
    cmd:         4'h0,
    evstat:      DSU_EVSTAT_RST,
    hot_plug_enable_flag:         DSU_HPE_RST,
    dirty:       2'h0,
    probe:       1'b0,
    locked:      1'b0,
    strap_taken: 1'b0,
    addr:        DSU_ADDR_RST,
    length:      DSU_LENGTH_RST,
    value:       DSU_VALUE_RST,
    chan0:       DSU_CHAN_RST,
    chan1:       DSU_CHAN_RST
  };

endpackage : dsu_pkg

// *** rtl/dsu_lane_merge.sv ***
// Byte-lane merge of a bus write into a stored 32-bit word
`timescale 1ns/10ps
module dsu_lane_merge (
  input  wire logic [31:0] i_old,
  input  wire logic [31:0] i_new,
  input  wire logic [3:0]  i_sel,
  output logic      [31:0] o_merged
);

  // --------------------------------------------------------------------------
  // Each selected lane takes the new byte, others keep the old one
  // --------------------------------------------------------------------------
  always_comb begin
    for (int lane = 0; lane < 4; lane++) begin
      o_merged[lane*8 +: 8] = i_sel[lane] ? i_new[lane*8 +: 8] : i_old[lane*8 +: 8];
    end
  end

endmodule : dsu_lane_merge

// *** rtl/dsu_regs.sv ***
// Register front end of the debug and service unit with a classic Wishbone slave
//
// Functional notes
// (R1) Byte, halfword and word accesses via lane selects
// (R2) Guard protection drops writes to protected registers
// (R3) Reserved bits read zero; software writes zero
// (R4) Control bit 4 one starts chip erase
// (R5) Control bit 3 one starts memory self-test
// (R6) Control bit 2 one starts CRC computation
// (R7) Control bit 0 one resets the unit
// (R8) Writing one clears an event flag
// (R9) Forbidden command while locked sets protection error
// (R10) Operation failure sets failure flag
// (R11) Detected bus error sets bus error flag
// (R12) Cold-plugged adapter sets reset-extension flag
// (R13) Operation completion sets done flag
// (R14) Hot-plug enable resets one, clears on pin change
// (R15) Channel write sets dirty, read clears it
// (R16) Probe-present flag sets on detection, sticks
// (R17) Locked flag caught at power-up, sticks
// (R18) Address register holds word address and mode
// (R19) Length register holds word count, low bits zero
// (R20) Value register holds seed, then result
// (R21) Command bits are one-cycle triggers reading zero
`timescale 1ns/10ps
module dsu_regs
  import dsu_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic      [31:0] o_wb_dat,
  input  wire logic        i_guard_protect,
  input  wire logic        i_locked_strap,
  input  wire dsu_evt_t    i_evt,
  input  wire logic [31:0] i_result_data,
  output dsu_cmd_t         o_cmd,
  output logic      [29:0] o_op_word_addr,
  output logic      [1:0]  o_access_mode,
  output logic      [29:0] o_op_word_count,
  output logic      [31:0] o_op_value,
  output logic             o_locked,
  output logic             o_probe_present,
  output logic             o_hot_plug_enable,
  output logic             o_cpu_reset_extension,
  output logic      [1:0]  o_channel_dirty
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  dsu_state_t  st;
  dsu_state_t  next_st;

  logic        req;
  logic        xfer;
  logic        wr;
  logic        rd;
  logic        wr_ok;
  logic        ctrl_lane;
  logic [5:0]  idx;
  logic [31:0] cur_word;
  logic [31:0] merged;

  // --------------------------------------------------------------------------
  // Register read view
  // --------------------------------------------------------------------------
  function automatic logic [31:0] read_view(input dsu_state_t s, input logic [5:0] ix);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (ix)
      DSU_IDX_CTRL:   w = 32'h0000_0000;                                     // R21
      DSU_IDX_EVSTAT: w[DSU_EV_PROTECTION_ERROR_FLAG_BIT:DSU_EV_DONE_BIT] = s.evstat;        // R3
      DSU_IDX_PRSTAT: begin
        w[DSU_PR_HPE_BIT]                      = s.hot_plug_enable_flag;
        w[DSU_PR_DIRTY_LSB +: 2]               = s.dirty;
        w[DSU_PR_PROBE_BIT]                    = s.probe;
        w[DSU_PR_LOCKED_BIT]                   = s.locked;
      end
      DSU_IDX_ADDR:   w = s.addr;                                            // R18
      DSU_IDX_LENGTH: w = {s.length, 2'b00};                                 // R19
      DSU_IDX_VALUE:  w = s.value;                                           // R20
      DSU_IDX_CHAN0:  w = s.chan0;
      DSU_IDX_CHAN1:  w = s.chan1;
      default:        w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_view

  function automatic logic is_protected(input logic [5:0] ix);
    logic p;
    p = 1'b0;
    unique case (ix)
      DSU_IDX_CTRL, DSU_IDX_EVSTAT, DSU_IDX_PRSTAT,
      DSU_IDX_ADDR, DSU_IDX_LENGTH, DSU_IDX_VALUE: p = 1'b1;
      default:                                     p = 1'b0;
    endcase
    return p;
  endfunction : is_protected

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign req       = i_wb_cyc & i_wb_stb;
  assign xfer      = req & st.ack;
  assign wr        = xfer & i_wb_we;
  assign rd        = xfer & ~i_wb_we;
  assign idx       = i_wb_adr[7:2];
  assign wr_ok     = wr & ~(i_guard_protect & is_protected(idx));    // R2
  assign ctrl_lane = i_wb_sel[0];
  assign cur_word  = read_view(st, idx);

  dsu_lane_merge u_merge (
    .i_old    (cur_word),
    .i_new    (i_wb_dat),
    .i_sel    (i_wb_sel),
    .o_merged (merged)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_st     = st;
    next_st.cmd = '0;                                                        // R21

    // Ack one cycle after the request, dropped the cycle after
    next_st.ack   = req & ~st.ack;
    next_st.rdata = 32'h0000_0000;
    if (req & ~st.ack & ~i_wb_we) begin
      next_st.rdata = cur_word;
    end

    // Strap is caught on the first cycle after reset release
    if (!st.strap_taken) begin
      next_st.strap_taken = 1'b1;
      next_st.locked      = i_locked_strap;                                  // R17
    end

    // Software writes, taken at the edge where ack is sampled high
    if (wr_ok) begin
      unique case (idx)
        DSU_IDX_CTRL: begin
          if (ctrl_lane) begin
            if (i_wb_dat[DSU_CTRL_CE_BIT]) begin
              next_st.cmd.chip_erase = 1'b1;                                 // R4
            end
            if (i_wb_dat[DSU_CTRL_SELFTEST_BIT]) begin
              if (st.locked) begin
                next_st.evstat[DSU_EV_PROTECTION_ERROR_FLAG_BIT] = 1'b1;                      // R9
              end else begin
                next_st.cmd.selftest = 1'b1;                                 // R5
              end
            end
            if (i_wb_dat[DSU_CTRL_CRC_BIT]) begin
              if (st.locked) begin
                next_st.evstat[DSU_EV_PROTECTION_ERROR_FLAG_BIT] = 1'b1;                      // R9
              end else begin
                next_st.cmd.crc = 1'b1;                                      // R6
              end
            end
          end
        end
        DSU_IDX_EVSTAT: begin
          if (ctrl_lane) begin
            next_st.evstat = st.evstat & ~i_wb_dat[4:0];                     // R8
          end
        end
        DSU_IDX_ADDR:   next_st.addr   = merged;                             // R1 R18
        DSU_IDX_LENGTH: next_st.length = merged[31:DSU_WORD_LSB];            // R19
        DSU_IDX_VALUE:  next_st.value  = merged;                             // R20
        DSU_IDX_CHAN0: begin
          next_st.chan0    = merged;
          next_st.dirty[0] = 1'b1;                                           // R15
        end
        DSU_IDX_CHAN1: begin
          next_st.chan1    = merged;
          next_st.dirty[1] = 1'b1;                                           // R15
        end
        default: begin
        end
      endcase
    end

    // Channel reads clear their dirty flag
    if (rd && idx == DSU_IDX_CHAN0) begin
      next_st.dirty[0] = 1'b0;                                               // R15
    end
    if (rd && idx == DSU_IDX_CHAN1) begin
      next_st.dirty[1] = 1'b0;                                               // R15
    end

    // Hardware events, after the clears so that a set wins
    if (i_evt.op_fail) begin
      next_st.evstat[DSU_EV_FAIL_BIT] = 1'b1;                                // R10
    end
    if (i_evt.bus_err) begin
      next_st.evstat[DSU_EV_BUS_ERROR_FLAG_BIT] = 1'b1;                                // R11
    end
    if (i_evt.cold_plug) begin
      next_st.evstat[DSU_EV_RSTEXT_BIT] = 1'b1;                              // R12
    end
    if (i_evt.op_done) begin
      next_st.evstat[DSU_EV_DONE_BIT] = 1'b1;                                // R13
    end
    if (i_evt.result_valid) begin
      next_st.value = i_result_data;                                         // R20
    end
    if (i_evt.swclk_func_changed) begin
      next_st.hot_plug_enable_flag = 1'b0;                                                    // R14
    end
    if (i_evt.probe_detect) begin
      next_st.probe = 1'b1;                                                  // R16
    end

    // Soft reset returns the unit to reset state, probe, locked and hot-plug enable flags kept
    if (wr_ok && idx == DSU_IDX_CTRL && ctrl_lane && i_wb_dat[DSU_CTRL_SOFT_RESET_TRIGGER_BIT]) begin
      next_st.cmd        = '0;                                               // R7
      next_st.cmd.unit_reset = 1'b1;                                         // R7
      next_st.evstat     = DSU_EVSTAT_RST;                                   // R7
      next_st.dirty      = 2'h0;
      next_st.addr       = DSU_ADDR_RST;
      next_st.length     = DSU_LENGTH_RST;
      next_st.value      = DSU_VALUE_RST;
      next_st.chan0      = DSU_CHAN_RST;
      next_st.chan1      = DSU_CHAN_RST;
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st <= DSU_STATE_RST;                                                   // R14
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_wb_ack              = st.ack;
  assign o_wb_dat              = st.rdata;
  assign o_cmd                 = st.cmd;
  assign o_op_word_addr        = st.addr[31:DSU_WORD_LSB];                   // R18
  assign o_access_mode         = st.addr[1:0];                               // R18
  assign o_op_word_count       = st.length;                                  // R19
  assign o_op_value            = st.value;
  assign o_locked              = st.locked;
  assign o_probe_present       = st.probe;
  assign o_hot_plug_enable     = st.hot_plug_enable_flag;
  assign o_cpu_reset_extension = st.evstat[DSU_EV_RSTEXT_BIT];               // R12
  assign o_channel_dirty       = st.dirty;

endmodule : dsu_regs

// *** verification/dsu_engine_model.sv ***
// Operation engine model answering service unit commands
`timescale 1ns/10ps
module dsu_engine_model
  import dsu_pkg::*;
#(
  parameter int DELAY = 4
)
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire dsu_cmd_t    i_cmd,
  input  wire logic [31:0] i_seed,
  output dsu_evt_t         o_evt,
  output logic      [31:0] o_result
);
  int cnt;
  always @(posedge i_clk) begin
    o_evt <= '0;
    if (i_srst || i_cmd.unit_reset) begin
      cnt <= 0;
    end else if (i_cmd.chip_erase || i_cmd.selftest || i_cmd.crc) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        o_evt.op_done <= 1'b1;
        o_evt.result_valid <= 1'b1;
        o_result <= ~i_seed;
      end
    end
  end
endmodule : dsu_engine_model

// *** verification/dsu_regs_checker.sv ***
// Port assertions for the service unit register front end
`timescale 1ns/10ps
module dsu_regs_checker
  import dsu_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic        o_wb_ack,
  input  wire logic [31:0] o_wb_dat,
  input  wire logic        i_guard_protect,
  input  wire logic        i_locked_strap,
  input  wire dsu_evt_t    i_evt,
  input  wire logic [31:0] i_result_data,
  input  wire dsu_cmd_t    o_cmd,
  input  wire logic [29:0] o_op_word_addr,
  input  wire logic [1:0]  o_access_mode,
  input  wire logic [29:0] o_op_word_count,
  input  wire logic [31:0] o_op_value,
  input  wire logic        o_locked,
  input  wire logic        o_probe_present,
  input  wire logic        o_hot_plug_enable,
  input  wire logic        o_cpu_reset_extension,
  input  wire logic [1:0]  o_channel_dirty
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire req    = i_wb_cyc && i_wb_stb;
  wire ctl_wr = req && o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr[7:2] == 6'h00
                && !i_guard_protect;
  wire soft_rst = ctl_wr && i_wb_dat[0];
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_ack_timely: assert property (req && !o_wb_ack |=> o_wb_ack)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (o_wb_ack |-> $past(req) ##1 !o_wb_ack)
    else $error("ack without request or too long");
  a_rdata_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
    else $error("read data outside ack");
  a_cmd_single: assert property (o_cmd != 4'h0 |=> o_cmd == 4'h0)
    else $error("command longer than one cycle");
  a_erase_cause: assert property (o_cmd.chip_erase |-> $past(ctl_wr && i_wb_dat[4]))
    else $error("erase without control write");
  a_test_cause: assert property (
    o_cmd.selftest || o_cmd.crc |-> !o_locked && $past(ctl_wr))
    else $error("test start without write or while locked");
  a_soft_reset: assert property (ctl_wr && i_wb_dat[0] |=> o_cmd.unit_reset)
    else $error("soft reset not triggered");
  a_rstext_set: assert property (
    i_evt.cold_plug && !soft_rst |=> o_cpu_reset_extension)
    else $error("reset extension not set");
  a_hpe_clear: assert property (
    i_evt.swclk_func_changed || !o_hot_plug_enable |=> !o_hot_plug_enable)
    else $error("hot plug enable not cleared or set again");
  a_probe_stick: assert property (i_evt.probe_detect || o_probe_present |=> o_probe_present)
    else $error("probe flag not set or lost");
  a_locked_stick: assert property (o_locked |=> o_locked)
    else $error("locked flag cleared");
  a_value_load: assert property (
    i_evt.result_valid && !soft_rst |=> o_op_value == $past(i_result_data))
    else $error("result not loaded");
endmodule : dsu_regs_checker

// *** verification/tb.sv ***
// Self-checking bench for the service unit register front end
`timescale 1ns/10ps
module tb
  import dsu_pkg::*;
;
  logic        i_clk, i_srst, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
  logic        i_guard_protect, i_locked_strap, o_locked, o_probe_present;
  logic        o_hot_plug_enable, o_cpu_reset_extension;
  logic [7:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, i_result_data, o_op_value, rd;
  logic [29:0] o_op_word_addr, o_op_word_count;
  logic [1:0]  o_access_mode, o_channel_dirty;
  dsu_cmd_t    o_cmd;
  dsu_evt_t    i_evt, eng_evt, tb_evt;
  int          fails, check_count;
  assign i_evt = eng_evt | tb_evt;
  dsu_regs dsu_regs_i (
    .i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_guard_protect(i_guard_protect),
    .i_locked_strap(i_locked_strap), .i_evt(i_evt), .i_result_data(i_result_data),
    .o_cmd(o_cmd), .o_op_word_addr(o_op_word_addr), .o_access_mode(o_access_mode),
    .o_op_word_count(o_op_word_count), .o_op_value(o_op_value), .o_locked(o_locked),
    .o_probe_present(o_probe_present), .o_hot_plug_enable(o_hot_plug_enable),
    .o_cpu_reset_extension(o_cpu_reset_extension), .o_channel_dirty(o_channel_dirty));
  dsu_engine_model dsu_engine_model_i (.i_clk(i_clk), .i_srst(i_srst), .i_cmd(o_cmd),
    .i_seed(o_op_value), .o_evt(eng_evt), .o_result(i_result_data));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge i_clk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} <= {2'b11, we, a, s, d};
    do @(posedge i_clk); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb} <= 2'b00;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    wb(1'b1, a, s, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 4'hF, 32'h0);
    chk(rd, exp);
  endtask : rdchk
  task automatic ev(input dsu_evt_t e);
    @(posedge i_clk);
    tb_evt <= e;
    @(posedge i_clk);
    tb_evt <= '0;
  endtask : ev
  task automatic do_reset(input logic s);
    i_locked_strap <= s;
    i_srst <= 1'b1;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
  endtask : do_reset
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    rdchk(8'h04, 32'h00);
    rdchk(8'h08, 32'h10);
    rdchk(8'h60, 32'h00);
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'hFFFF_FFFF);
    chk({o_op_word_addr, o_access_mode}, 32'hFFFF_FFFF);
    wr(8'h20, 4'hF, 32'hFFFF_FFFC);
    rdchk(8'h20, 32'hFFFF_FFFC);
    chk({2'b00, o_op_word_count}, 32'h3FFF_FFFF);
    wr(8'h30, 4'b0100, 32'h12AB_3456);
    wr(8'h30, 4'b0011, 32'h7777_BEEF);
    rdchk(8'h30, 32'h00AB_BEEF);
    i_guard_protect <= 1'b1;
    wr(8'h10, 4'hF, 32'h0);
    rdchk(8'h10, 32'hFFFF_FFFF);
    i_guard_protect <= 1'b0;
    wr(8'h08, 4'hF, 32'h0);
    rdchk(8'h08, 32'h10);
    wr(8'h00, 4'h1, 32'h00);
    rdchk(8'h00, 32'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ops;
    logic [31:0] cd[4] = '{32'h10, 32'h08, 32'h04, 32'h00};
    wr(8'h30, 4'hF, 32'h0F0F_1234);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 4'h1, cd[i]);
      @(posedge i_clk);
      chk({28'h0, o_cmd}, cd[i] >> 1);
    end
    rdchk(8'h00, 32'h00);
    repeat (8) @(posedge i_clk);
    rdchk(8'h04, 32'h01);
    rdchk(8'h30, 32'hF0F0_EDCB);
    wr(8'h04, 4'h1, 32'h00);
    rdchk(8'h04, 32'h01);
    wr(8'h04, 4'h1, 32'h01);
    rdchk(8'h04, 32'h00);
    wr(8'h00, 4'h1, 32'h01);
    @(posedge i_clk);
    chk({28'h0, o_cmd}, 32'h1);
    rdchk(8'h10, 32'h00);
    rdchk(8'h08, 32'h10);
    $display("test ops done");
  endtask : t_ops
  task automatic t_events;
    ev(7'h3C);
    rdchk(8'h04, 32'h0E);
    rdchk(8'h08, 32'h12);
    wr(8'h04, 4'h1, 32'h06);
    rdchk(8'h04, 32'h08);
    wr(8'h40, 4'hF, 32'hCAFE_0001);
    wr(8'h50, 4'hC, 32'h5A5A_0000);
    rdchk(8'h08, 32'h1E);
    chk({30'h0, o_channel_dirty}, 32'h3);
    rdchk(8'h40, 32'hCAFE_0001);
    rdchk(8'h08, 32'h1A);
    rdchk(8'h50, 32'h5A5A_0000);
    rdchk(8'h08, 32'h12);
    ev(7'h02);
    rdchk(8'h08, 32'h02);
    $display("test events done");
  endtask : t_events
  task automatic t_locked;
    do_reset(1'b1);
    rdchk(8'h08, 32'h11);
    wr(8'h00, 4'h1, 32'h08);
    @(posedge i_clk);
    chk({28'h0, o_cmd}, 32'h0);
    rdchk(8'h04, 32'h10);
    wr(8'h00, 4'h1, 32'h10);
    @(posedge i_clk);
    chk({28'h0, o_cmd}, 32'h8);
    $display("test locked done");
  endtask : t_locked
  initial begin
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} = '0;
    {i_guard_protect, i_locked_strap, i_srst, tb_evt} = {3'b001, 7'h00};
    fails = 0;
    check_count = 0;
    do_reset(1'b0);
    t_regs;
    t_ops;
    t_events;
    t_locked;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    final_report;
  end
endmodule : tb
bind dsu_regs dsu_regs_checker dsu_regs_checker_i (
  .i_clk(i_clk), .i_srst(i_srst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_guard_protect(i_guard_protect),
  .i_locked_strap(i_locked_strap), .i_evt(i_evt), .i_result_data(i_result_data),
  .o_cmd(o_cmd), .o_op_word_addr(o_op_word_addr), .o_access_mode(o_access_mode),
  .o_op_word_count(o_op_word_count), .o_op_value(o_op_value), .o_locked(o_locked),
  .o_probe_present(o_probe_present), .o_hot_plug_enable(o_hot_plug_enable),
  .o_cpu_reset_extension(o_cpu_reset_extension), .o_channel_dirty(o_channel_dirty));
